// File: hdl/cbc_bus_ctl.sv
module cbc_bus_ctl #(
	parameter int BEATS_W = cbc_pkg::CBC_BEATS_W
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_req_valid,
	input wire cbc_pkg::cbc_kind_t i_req_kind,
	input wire logic [BEATS_W-1:0] i_req_beats,
	input wire logic i_req_lock_prefix,
	input wire logic i_req_sys_lock,
	input wire logic i_req_lock_more,
	input wire logic i_req_code_prefetch,
	input wire logic i_req_cacheable,
	input wire logic i_req_burstable,
	input wire logic i_req_paged,
	input wire logic [cbc_pkg::CBC_LANES-1:0] i_req_byte_en,
	input wire logic i_paging_en,
	input wire logic i_pte_nocache,
	input wire logic i_pte_writethru,
	input wire logic i_cache_off_bit,
	input wire logic i_cycle_done_n,
	input wire logic i_bus_size8_n,
	input wire logic i_bus_size16_n,
	input wire logic i_hold,
	input wire logic i_nmi,
	input wire logic [cbc_pkg::CBC_DATA_W-1:0] i_data,
	input wire logic [cbc_pkg::CBC_LANES-1:0] i_data_parity,
	output logic o_req_ready,
	output logic o_cycle_active,
	output logic o_beat_done,
	output logic o_rd_valid,
	output logic [cbc_pkg::CBC_DATA_W-1:0] o_rd_data,
	output logic o_lock_n,
	output logic o_lock_oe,
	output logic o_mem_io,
	output logic o_mem_io_oe,
	output logic o_multi_cycle_hold_n,
	output logic o_multi_cycle_hold_oe,
	output logic o_page_nocache_out,
	output logic o_page_nocache_oe,
	output logic o_page_writethru_out,
	output logic o_page_writethru_oe,
	output logic o_bus_grant_out,
	output logic o_parity_error_n,
	output logic o_nmi_take,
	output logic [7:0] o_nmi_vector
);
	import cbc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	wire [CBC_SYNC_W-1:0] pins_level;
	wire done_n_f;
	wire size8_n_f;
	wire size16_n_f;
	wire hold_f;
	wire nmi_f;

	cbc_sync #(
		.WIDTH(CBC_SYNC_W),
		.RESET_VAL(CBC_SYNC_RST)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_pin({i_cycle_done_n, i_bus_size8_n, i_bus_size16_n, i_hold, i_nmi}),
		.o_level(pins_level)
	);

	assign done_n_f = pins_level[4];
	assign size8_n_f = pins_level[3];
	assign size16_n_f = pins_level[2];
	assign hold_f = pins_level[1];
	assign nmi_f = pins_level[0];

	////////////////////////////////////////////////////////////////////////////
	// state

	cbc_state_t state;
	cbc_state_t next_state;
	cbc_kind_t cur_kind;
	logic [BEATS_W-1:0] beats_left;
	logic [BEATS_W-1:0] next_beats_left;
	logic [CBC_LANES-1:0] cur_be;
	logic cur_lock_more;
	logic cur_nc_prefetch;
	logic lock_on;
	logic next_lock;
	logic multi_cycle_hold_n_on;
	logic next_multi_cycle_hold_n;
	logic done_armed;
	logic next_armed;
	logic nmi_prev;

	////////////////////////////////////////////////////////////////////////////
	// decode

	wire take_req;
	wire beat_end;
	wire last_beat;
	wire cur_is_read;
	wire cur_par_checked;
	wire [CBC_LANES-1:0] lane_mask;
	wire [CBC_LANES-1:0] lane_bad;
	wire par_err;
	wire req_is_mem;
	wire req_locks;
	wire req_multi;
	wire grant_idle;
	wire grant_boundary;
	wire nmi_edge;

	assign take_req = (state == CBC_ST_IDLE) && i_req_valid && o_req_ready;

	// a done level held over from the last beat must not end the next one
	assign beat_end = (state == CBC_ST_XFER) && !done_n_f && done_armed;
	assign last_beat = (beats_left <= BEATS_W'(1));

	assign cur_is_read = (cur_kind == CBC_KIND_MEM_RD) || (cur_kind == CBC_KIND_IO_RD) ||
		(cur_kind == CBC_KIND_INTACK) || (cur_kind == CBC_KIND_COPRO_RD);
	assign cur_par_checked = (cur_kind == CBC_KIND_MEM_RD) || (cur_kind == CBC_KIND_IO_RD);

	assign lane_mask = !size8_n_f ? CBC_MASK_BUS8 :
		!size16_n_f ? CBC_MASK_BUS16 : CBC_MASK_BUS32;

	// even parity over each byte and its parity bit
	genvar lane;
	generate
		for (lane = 0; lane < CBC_LANES; lane++) begin : g_lane
			assign lane_bad[lane] = ^{i_data[lane*8 +: 8], i_data_parity[lane]};
		end
	endgenerate

	assign par_err = beat_end && cur_par_checked && |(lane_bad & lane_mask & cur_be);

	assign req_is_mem = (i_req_kind == CBC_KIND_MEM_RD) || (i_req_kind == CBC_KIND_MEM_WR);
	assign req_locks = i_req_sys_lock || i_req_lock_prefix;
	assign req_multi = (i_req_beats > BEATS_W'(1));

	// hold only in idle, outside any locked sequence, when no request is taken
	assign grant_idle = (state == CBC_ST_IDLE) && !take_req && hold_f && !lock_on;

	// mid-transfer release only for noncacheable nonburst code fetches
	assign grant_boundary = beat_end && !last_beat && hold_f && !lock_on && cur_nc_prefetch;

	assign nmi_edge = nmi_f && !nmi_prev;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		unique case (state)
			CBC_ST_IDLE: begin
				if (take_req) begin
					next_state = CBC_ST_XFER;
				end else if (grant_idle) begin
					next_state = CBC_ST_GRANT;
				end
			end
			CBC_ST_XFER: begin
				if (beat_end && last_beat) begin
					next_state = CBC_ST_IDLE;
				end else if (grant_boundary) begin
					next_state = CBC_ST_GRANT;
				end
			end
			CBC_ST_GRANT: begin
				if (!hold_f) begin
					next_state = (beats_left != '0) ? CBC_ST_XFER : CBC_ST_IDLE;
				end
			end
			default: begin
				next_state = CBC_ST_IDLE;
			end
		endcase
	end

	always_comb begin
		next_beats_left = beats_left;
		if (take_req) begin
			next_beats_left = (i_req_beats == '0) ? BEATS_W'(1) : i_req_beats;
		end else if (beat_end) begin
			next_beats_left = beats_left - BEATS_W'(1);
		end
	end

	// lock runs from the first request of a sequence to the end of its last
	always_comb begin
		next_lock = lock_on;
		if (take_req) begin
			next_lock = req_locks || lock_on;
		end else if (beat_end && last_beat && !cur_lock_more) begin
			next_lock = 1'b0;
		end
	end

	always_comb begin
		next_multi_cycle_hold_n = multi_cycle_hold_n_on;
		if (take_req) begin
			next_multi_cycle_hold_n = req_multi;
		end else if (beat_end && last_beat) begin
			next_multi_cycle_hold_n = 1'b0;
		end
	end

	always_comb begin
		next_armed = done_armed;
		if (beat_end) begin
			next_armed = 1'b0;
		end else if (done_n_f) begin
			next_armed = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= CBC_ST_IDLE;
			beats_left <= '0;
			lock_on <= 1'b0;
			multi_cycle_hold_n_on <= 1'b0;
			done_armed <= 1'b0;
			nmi_prev <= 1'b0;
		end else begin
			state <= next_state;
			beats_left <= next_beats_left;
			lock_on <= next_lock;
			multi_cycle_hold_n_on <= next_multi_cycle_hold_n;
			done_armed <= next_armed;
			nmi_prev <= nmi_f;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cur_kind <= CBC_KIND_MEM_RD;
			cur_be <= '0;
			cur_lock_more <= 1'b0;
			cur_nc_prefetch <= 1'b0;
		end else if (take_req) begin
			cur_kind <= i_req_kind;
			cur_be <= i_req_byte_en;
			cur_lock_more <= i_req_lock_more;
			cur_nc_prefetch <= i_req_code_prefetch && !i_req_cacheable && !i_req_burstable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus-cycle-definition outputs

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_req_ready <= 1'b0;
			o_cycle_active <= 1'b0;
			o_bus_grant_out <= CBC_RST_GRANT;
			o_lock_n <= CBC_RST_LOCK_N;
			o_multi_cycle_hold_n <= CBC_RST_MULTI_CYCLE_HOLD_N_N;
		end else begin
			// pending hold keeps the core off the bus, unless a locked sequence must finish first
			o_req_ready <= (next_state == CBC_ST_IDLE) && (!hold_f || next_lock);
			o_cycle_active <= (next_state == CBC_ST_XFER);
			o_bus_grant_out <= (next_state == CBC_ST_GRANT);
			o_lock_n <= !next_lock;
			o_multi_cycle_hold_n <= !next_multi_cycle_hold_n;
		end
	end

	// every three-state output floats together with the grant
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_lock_oe <= CBC_RST_OE;
			o_mem_io_oe <= CBC_RST_OE;
			o_multi_cycle_hold_oe <= CBC_RST_OE;
			o_page_nocache_oe <= CBC_RST_OE;
			o_page_writethru_oe <= CBC_RST_OE;
		end else begin
			o_lock_oe <= (next_state != CBC_ST_GRANT);
			o_mem_io_oe <= (next_state != CBC_ST_GRANT);
			o_multi_cycle_hold_oe <= (next_state != CBC_ST_GRANT);
			o_page_nocache_oe <= (next_state != CBC_ST_GRANT);
			o_page_writethru_oe <= (next_state != CBC_ST_GRANT);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_io <= CBC_RST_MEM_IO;
			o_page_nocache_out <= 1'b0;
			o_page_writethru_out <= 1'b0;
		end else if (take_req) begin
			o_mem_io <= req_is_mem;
			o_page_nocache_out <= i_paging_en && i_req_paged && i_pte_nocache && !i_cache_off_bit;
			o_page_writethru_out <= i_paging_en && i_req_paged && i_pte_writethru;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data return and parity report

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_beat_done <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
			o_parity_error_n <= CBC_RST_PAR_N;
		end else begin
			o_beat_done <= beat_end;
			o_rd_valid <= beat_end && cur_is_read;
			if (beat_end && cur_is_read) begin
				o_rd_data <= i_data;
			end
			// report only; data is still handed on unchanged
			o_parity_error_n <= !par_err;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// unmaskable interrupt: vector made here, no acknowledge cycles run

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_nmi_take <= 1'b0;
			o_nmi_vector <= CBC_NMI_VECTOR;
		end else begin
			o_nmi_take <= nmi_edge;
			if (nmi_edge) begin
				o_nmi_vector <= CBC_NMI_VECTOR;
			end
		end
	end

endmodule

// File: hdl/cbc_sync.sv
module cbc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agree;
	wire [WIDTH-1:0] next_level;

	// a change counts only once stages two and three agree
	assign agree = ~(stage2 ^ stage3);
	assign next_level = (agree & stage3) | (~agree & o_level);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
			o_level <= RESET_VAL;
		end else begin
			stage1 <= i_pin;
			stage2 <= stage1;
			stage3 <= stage2;
			o_level <= next_level;
		end
	end

endmodule

// File: inc/cbc_pkg.sv
package cbc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// bus cycle kinds as the core presents them
	typedef enum logic [2:0] {
		CBC_KIND_MEM_RD = 3'h0,
		CBC_KIND_MEM_WR = 3'h1,
		CBC_KIND_IO_RD = 3'h2,
		CBC_KIND_IO_WR = 3'h3,
		CBC_KIND_INTACK = 3'h4,
		CBC_KIND_SPECIAL = 3'h5,
		CBC_KIND_COPRO_RD = 3'h6,
		CBC_KIND_COPRO_WR = 3'h7
	} cbc_kind_t;

	// gray codes along idle -> transfer -> grant
	typedef enum logic [1:0] {
		CBC_ST_IDLE = 2'h0,
		CBC_ST_XFER = 2'h1,
		CBC_ST_GRANT = 2'h3
	} cbc_state_t;

	////////////////////////////////////////////////////////////////////////////
	localparam int CBC_DATA_W = 32;
	localparam int CBC_LANES = 4;
	localparam int CBC_BEATS_W = 3;
	localparam logic [7:0] CBC_NMI_VECTOR = 8'h02;

	// valid byte lanes per bus size
	localparam logic [3:0] CBC_MASK_BUS8 = 4'h1;
	localparam logic [3:0] CBC_MASK_BUS16 = 4'h3;
	localparam logic [3:0] CBC_MASK_BUS32 = 4'hf;

	// pin synchroniser order {done_n, size8_n, size16_n, hold, nmi}
	localparam int CBC_SYNC_W = 5;
	localparam logic [4:0] CBC_SYNC_RST = 5'h1c;

	// output reset values
	localparam logic CBC_RST_LOCK_N = 1'b1;
	localparam logic CBC_RST_MEM_IO = 1'b0;
	localparam logic CBC_RST_MULTI_CYCLE_HOLD_N_N = 1'b1;
	localparam logic CBC_RST_OE = 1'b1;
	localparam logic CBC_RST_PAR_N = 1'b1;
	localparam logic CBC_RST_GRANT = 1'b0;

endpackage

// File: testbench/cbc_bus_ctl_sva.sv
module cbc_bus_ctl_sva
	import cbc_pkg::*;
#(
	parameter int BEATS_W = 3
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_req_valid,
	input wire cbc_pkg::cbc_kind_t i_req_kind,
	input wire logic [BEATS_W-1:0] i_req_beats,
	input wire logic i_req_lock_prefix,
	input wire logic i_req_sys_lock,
	input wire logic i_req_paged,
	input wire logic i_paging_en,
	input wire logic i_pte_nocache,
	input wire logic i_pte_writethru,
	input wire logic i_cache_off_bit,
	input wire logic i_nmi,
	input wire logic o_req_ready,
	input wire logic o_cycle_active,
	input wire logic o_beat_done,
	input wire logic o_rd_valid,
	input wire logic o_lock_n,
	input wire logic o_lock_oe,
	input wire logic o_mem_io,
	input wire logic o_mem_io_oe,
	input wire logic o_multi_cycle_hold_n,
	input wire logic o_multi_cycle_hold_oe,
	input wire logic o_page_nocache_out,
	input wire logic o_page_nocache_oe,
	input wire logic o_page_writethru_out,
	input wire logic o_page_writethru_oe,
	input wire logic o_bus_grant_out,
	input wire logic o_parity_error_n,
	input wire logic o_nmi_take,
	input wire logic [7:0] o_nmi_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	// ready only rises in idle, so valid and ready mark a take
	logic take;
	assign take = i_req_valid && o_req_ready;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	////////////////////////////////
	AST_NO_GRANT_LOCK: assert property (!o_lock_n |-> !o_bus_grant_out)
		else $error("grant while locked");
	AST_FLOAT: assert property (o_bus_grant_out |->
		!(o_lock_oe | o_mem_io_oe | o_multi_cycle_hold_oe | o_page_nocache_oe | o_page_writethru_oe))
		else $error("cycle outputs driven while granted");
	AST_MEM_IO: assert property (take |=> o_mem_io == ($past(i_req_kind) inside {CBC_KIND_MEM_RD, CBC_KIND_MEM_WR}))
		else $error("memory select wrong");
	AST_LOCK: assert property (take && (i_req_lock_prefix || i_req_sys_lock) |=> !o_lock_n)
		else $error("lock not asserted");
	AST_NOCACHE: assert property (take |=> o_page_nocache_out ==
		$past(i_paging_en && i_req_paged && i_pte_nocache && !i_cache_off_bit)) else $error("nocache wrong");
	AST_WRTHRU: assert property (take |=> o_page_writethru_out == $past(i_paging_en && i_req_paged && i_pte_writethru))
		else $error("writethru wrong");
	AST_MULTI_CYCLE_HOLD_N: assert property (take |=> o_multi_cycle_hold_n == ($past(i_req_beats) < 2))
		else $error("pseudo lock wrong");
	AST_PAR_SLOT: assert property (!o_parity_error_n |-> o_rd_valid && o_beat_done)
		else $error("parity error outside read return");
	AST_NMI: assert property ($rose(i_nmi) |-> ##[1:8] o_nmi_take)
		else $error("edge interrupt not taken");
	AST_VEC: assert property (o_nmi_vector == CBC_NMI_VECTOR)
		else $error("vector wrong");
	AST_END: assert property ($fell(o_cycle_active) |-> o_beat_done)
		else $error("cycle ended without done");
	cover property (!o_parity_error_n);
	cover property (o_bus_grant_out);
	cover property (o_nmi_take);
	cover property (!o_multi_cycle_hold_n && o_beat_done);
endmodule

// File: testbench/cbc_sys_model.sv
module cbc_sys_model (
	input wire logic i_clk,
	input wire logic i_active,
	input wire logic i_beat_done,
	input wire logic [31:0] i_word,
	input wire logic [3:0] i_bad,
	input wire logic [2:0] i_lat,
	output logic o_done_n,
	output logic [31:0] o_data,
	output logic [3:0] o_par
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	initial begin
		o_done_n = 1'b1;
		o_data = '0;
		o_par = '0;
		forever begin
			@(posedge i_clk);
			if (i_active) begin
				repeat (i_lat) @(posedge i_clk);
				// data first, done with it; held until the beat ends
				o_data <= i_word;
				o_par <= {^i_word[31:24], ^i_word[23:16], ^i_word[15:8], ^i_word[7:0]} ^ i_bad;
				o_done_n <= 1'b0;
				n = 0;
				do begin
					@(posedge i_clk);
					n++;
				end while (!i_beat_done && n < 40);
				// released bus shows no stale word
				o_done_n <= 1'b1;
				o_data <= ~i_word;
				repeat (2) @(posedge i_clk);
			end
		end
	end
endmodule

// File: testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cbc_pkg::*;
	logic i_clk, i_arst_n, i_req_valid, i_req_lock_prefix, i_req_sys_lock, i_req_lock_more, i_req_code_prefetch;
	logic i_req_cacheable, i_req_burstable, i_req_paged, i_paging_en, i_pte_nocache, i_pte_writethru;
	logic i_cache_off_bit, i_cycle_done_n, i_bus_size8_n, i_bus_size16_n, i_hold, i_nmi;
	cbc_kind_t i_req_kind;
	logic [2:0] i_req_beats, lat;
	logic [3:0] i_req_byte_en, i_data_parity, bad;
	logic [31:0] i_data, o_rd_data, word;
	logic o_req_ready, o_cycle_active, o_beat_done, o_rd_valid, o_lock_n, o_lock_oe, o_mem_io, o_mem_io_oe;
	logic o_multi_cycle_hold_n, o_multi_cycle_hold_oe, o_page_nocache_out, o_page_nocache_oe;
	logic o_page_writethru_out, o_page_writethru_oe, o_bus_grant_out, o_parity_error_n, o_nmi_take;
	logic [7:0] o_nmi_vector;
	logic held = 1'b0;
	int seed = 83, errors = 0, n_compared = 0, n;
	logic [31:0] exp_q[$];
	cbc_bus_ctl u_cbc_bus_ctl (.i_clk, .i_arst_n, .i_req_valid, .i_req_kind, .i_req_beats, .i_req_lock_prefix,
		.i_req_sys_lock, .i_req_lock_more, .i_req_code_prefetch, .i_req_cacheable, .i_req_burstable, .i_req_paged,
		.i_req_byte_en, .i_paging_en, .i_pte_nocache, .i_pte_writethru, .i_cache_off_bit, .i_cycle_done_n,
		.i_bus_size8_n, .i_bus_size16_n, .i_hold, .i_nmi, .i_data, .i_data_parity, .o_req_ready, .o_cycle_active,
		.o_beat_done, .o_rd_valid, .o_rd_data, .o_lock_n, .o_lock_oe, .o_mem_io, .o_mem_io_oe, .o_multi_cycle_hold_n,
		.o_multi_cycle_hold_oe, .o_page_nocache_out, .o_page_nocache_oe, .o_page_writethru_out,
		.o_page_writethru_oe, .o_bus_grant_out, .o_parity_error_n, .o_nmi_take, .o_nmi_vector);
	cbc_sys_model u_cbc_sys_model (.i_clk, .i_active(o_cycle_active), .i_beat_done(o_beat_done), .i_word(word),
		.i_bad(bad), .i_lat(lat), .o_done_n(i_cycle_done_n), .o_data(i_data), .o_par(i_data_parity));
	////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic xfer(input cbc_kind_t k, input logic [2:0] beats, input logic lk, input logic more = 1'b0,
		input logic nc = 1'b0);
		logic [3:0] m;
		logic perr, rd, rdv;
		logic [14:0] r;
		@(posedge i_clk);
		r = 15'($random(seed));
		// unlocked noncacheable nonburst code fetch
		if (nc)
			r[14:11] = 4'h4;
		i_req_kind <= k;
		i_req_beats <= beats;
		i_req_lock_prefix <= lk;
		i_req_lock_more <= more;
		i_req_valid <= 1'b1;
		{i_req_sys_lock, i_req_code_prefetch, i_req_cacheable, i_req_burstable, i_req_paged, i_paging_en,
			i_pte_nocache, i_pte_writethru, i_cache_off_bit, i_bus_size8_n, i_bus_size16_n, i_req_byte_en}
			<= r;
		word <= $random(seed);
		bad <= 4'($random(seed) & $random(seed));
		lat <= 3'($random(seed));
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (!o_req_ready && n < 50);
		chk(o_req_ready, 1'b1);
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		@(negedge i_clk);
		rd = (k == CBC_KIND_MEM_RD || k == CBC_KIND_IO_RD);
		rdv = k inside {CBC_KIND_MEM_RD, CBC_KIND_IO_RD, CBC_KIND_INTACK, CBC_KIND_COPRO_RD};
		m = !i_bus_size8_n ? CBC_MASK_BUS8 : !i_bus_size16_n ? CBC_MASK_BUS16 : CBC_MASK_BUS32;
		perr = rd && |(bad & i_req_byte_en & m);
		chk(o_mem_io, k inside {CBC_KIND_MEM_RD, CBC_KIND_MEM_WR});
		chk(o_lock_n, !(lk | i_req_sys_lock | held));
		held = (lk | i_req_sys_lock | held) & more;
		chk(o_multi_cycle_hold_n, beats < 2);
		chk(o_page_nocache_out, i_paging_en & i_req_paged & i_pte_nocache & !i_cache_off_bit);
		chk(o_page_writethru_out, i_paging_en & i_req_paged & i_pte_writethru);
		chk(o_parity_error_n, 1'b1);
		for (int b = 0; b < beats; b++) begin
			if (rdv)
				exp_q.push_back(word);
			n = 0;
			while (!o_beat_done && n < 99) begin
				@(negedge i_clk);
				n++;
			end
			chk(o_beat_done, 1'b1);
			chk(o_parity_error_n, !perr);
			chk(o_rd_valid, rdv);
			if (rdv)
				chk(o_rd_data, exp_q.pop_front());
			@(negedge i_clk);
		end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// span far above the sequence's thousand or so cycles
	initial begin
		#100000;
		errors++;
		conclude();
	end
	initial begin
		{i_arst_n, i_req_valid, i_req_lock_prefix, i_req_sys_lock, i_req_lock_more, i_req_code_prefetch,
			i_req_cacheable, i_req_burstable, i_req_paged, i_paging_en, i_pte_nocache, i_pte_writethru,
			i_cache_off_bit, i_hold, i_nmi} = '0;
		{i_bus_size8_n, i_bus_size16_n} = 2'h3;
		i_req_kind = CBC_KIND_MEM_RD;
		i_req_beats = 3'h1;
		i_req_byte_en = 4'hf;
		word = '0;
		bad = '0;
		lat = '0;
		repeat (8) @(posedge i_clk);
		i_arst_n <= 1'b1;
		for (int i = 0; i < 32; i++)
			xfer(cbc_kind_t'(3'(i)), 3'h1, 1'($random(seed)));
		xfer(CBC_KIND_MEM_RD, 3'h2, 1'b0);
		xfer(CBC_KIND_MEM_RD, 3'h4, 1'b1);
		// hold raised mid locked cycle: grant must wait for its end
		// lock carried into a second request: no grant in the gap
		fork
			begin
				xfer(CBC_KIND_MEM_WR, 3'h1, 1'b1, 1'b1);
				chk(o_bus_grant_out, 1'b0);
				xfer(CBC_KIND_MEM_RD, 3'h1, 1'b0);
			end
			begin
				repeat (3) @(posedge i_clk);
				i_hold <= 1'b1;
			end
		join
		n = 0;
		while (!o_bus_grant_out && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		chk(o_lock_n, 1'b1);
		chk(o_bus_grant_out, 1'b1);
		chk({o_lock_oe, o_mem_io_oe, o_page_nocache_oe, o_page_writethru_oe}, 4'h0);
		@(posedge i_clk);
		i_hold <= 1'b0;
		repeat (8) @(negedge i_clk);
		chk({o_bus_grant_out, o_lock_oe, o_mem_io_oe}, 3'h3);
		// hold during a noncacheable code fill: granted at a beat boundary
		fork
			xfer(CBC_KIND_MEM_RD, 3'h4, 1'b0, 1'b0, 1'b1);
			begin
				int w;
				w = 0;
				repeat (3) @(posedge i_clk);
				i_hold <= 1'b1;
				while (!o_bus_grant_out && w < 60) begin
					@(negedge i_clk);
					w++;
				end
				chk({o_bus_grant_out, o_multi_cycle_hold_oe, o_cycle_active}, 3'h4);
				@(posedge i_clk);
				i_hold <= 1'b0;
			end
		join
		@(posedge i_clk);
		i_nmi <= 1'b1;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (!o_nmi_take && n < 10);
		chk(o_nmi_take, 1'b1);
		chk({o_nmi_vector, o_cycle_active}, {CBC_NMI_VECTOR, 1'b0});
		@(posedge i_clk);
		i_nmi <= 1'b0;
		repeat (6) @(posedge i_clk);
		conclude();
	end
endmodule
bind cbc_bus_ctl cbc_bus_ctl_sva #(.BEATS_W(BEATS_W)) u_cbc_bus_ctl_sva (.i_clk, .i_arst_n, .i_req_valid,
	.i_req_kind, .i_req_beats, .i_req_lock_prefix, .i_req_sys_lock, .i_req_paged, .i_paging_en, .i_pte_nocache,
	.i_pte_writethru, .i_cache_off_bit, .i_nmi, .o_req_ready, .o_cycle_active, .o_beat_done, .o_rd_valid,
	.o_lock_n, .o_lock_oe, .o_mem_io, .o_mem_io_oe, .o_multi_cycle_hold_n, .o_multi_cycle_hold_oe,
	.o_page_nocache_out, .o_page_nocache_oe, .o_page_writethru_out, .o_page_writethru_oe, .o_bus_grant_out,
	.o_parity_error_n, .o_nmi_take, .o_nmi_vector);
